// File: verilog/port_data_latch_and_direction.sv
`timescale 1ns/1ps

module port_data_latch_and_direction (
  input wire logic clk,
  input wire logic reset_n,
  input wire port_latch_pkg::reg_req_t req,
  input wire logic [port_latch_pkg::NUM_PORTS-1:0][7:0] pin_direction_bit,
  input wire logic [1:0] ext_clock_mode,
  input wire logic [port_latch_pkg::NUM_PORTS-1:0][7:0] pin_in,
  output logic [port_latch_pkg::NUM_PORTS-1:0][7:0] pin_out,
  output logic [port_latch_pkg::NUM_PORTS-1:0][7:0] pin_oe,
  output logic [7:0] rd_data,
  output logic rd_valid
);

  // ******************************************************
  // address decode
  // ******************************************************
  // one-hot hit vector; zero for an unmapped address
  function automatic logic [port_latch_pkg::NUM_PORTS-1:0] port_hit(
    input logic [15:0] a
  );
    logic [port_latch_pkg::NUM_PORTS-1:0] h;

    h = '0;
    for (int i = 0; i < port_latch_pkg::NUM_PORTS; i++) begin
      h[i] = (a == port_latch_pkg::PORT_OFFSETS[i]);
    end
    return h;
  endfunction

  // an access that lands on no port at all
  function automatic logic no_hit(
    input logic [port_latch_pkg::NUM_PORTS-1:0] hit
  );
    logic none;

    none = (hit == '0);
    return none;
  endfunction

  // ******************************************************
  // write lanes
  // ******************************************************
  // a bit write opens one lane, a byte write all eight
  function automatic logic [7:0] lane_select(
    input logic bit_op,
    input logic [2:0] bit_sel
  );
    logic [7:0] m;

    m = 8'hff;
    if (bit_op) begin
      case (bit_sel)
        3'h0: m = 8'h01;
        3'h1: m = 8'h02;
        3'h2: m = 8'h04;
        3'h3: m = 8'h08;
        3'h4: m = 8'h10;
        3'h5: m = 8'h20;
        3'h6: m = 8'h40;
        3'h7: m = 8'h80;
        default: m = 8'h00;
      endcase
    end
    return m;
  endfunction

  // a bit write carries its value in wdata[0]
  function automatic logic [7:0] lane_value(
    input logic bit_op,
    input logic [7:0] wdata
  );
    logic [7:0] v;

    v = wdata;
    if (bit_op) begin
      v = {8{wdata[0]}};
    end
    return v;
  endfunction

  // open lanes take the new value, closed lanes keep the old one
  function automatic logic [7:0] merge_lanes(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic [7:0] lanes
  );
    logic [7:0] keep;
    logic [7:0] put;

    keep = old_val & ~lanes;
    put = new_val & lanes;
    return keep | put;
  endfunction

  // ******************************************************
  // read view
  // ******************************************************
  // latch bits that read as 0 while their pin takes an external clock
  function automatic logic [7:0] clock_pin_mask(
    input int port_index,
    input logic [1:0] mode
  );
    logic [7:0] z;

    z = 8'h00;
    if (port_index == port_latch_pkg::PORT12_INDEX) begin
      z[port_latch_pkg::CLOCK_PIN_A_BIT] = mode[0];
      z[port_latch_pkg::CLOCK_PIN_B_BIT] = mode[1];
    end
    return z;
  endfunction

  // input pins show the pin level, output pins the latch
  function automatic logic [7:0] pin_view(
    input logic [7:0] dir,
    input logic [7:0] level,
    input logic [7:0] latch
  );
    logic [7:0] from_pin;
    logic [7:0] from_latch;

    from_pin = dir & level;
    from_latch = ~dir & latch;
    return from_pin | from_latch;
  endfunction

  // and-or mux over the ports; ports not hit offer zero
  function automatic logic [7:0] merge_reads(
    input logic [port_latch_pkg::NUM_PORTS-1:0][7:0] lanes
  );
    logic [7:0] r;

    r = 8'h00;
    for (int i = 0; i < port_latch_pkg::NUM_PORTS; i++) begin
      r = r | lanes[i];
    end
    return r;
  endfunction

  // ******************************************************
  // state and decode
  // ******************************************************
  logic [port_latch_pkg::NUM_PORTS-1:0] wr_hit;
  logic [port_latch_pkg::NUM_PORTS-1:0] rd_hit;
  logic rd_miss;
  logic [7:0] lane_sel;
  logic [7:0] lane_val;

  // one byte per port, index order as in the port map
  logic [port_latch_pkg::NUM_PORTS-1:0][7:0] wr_lanes;
  logic [port_latch_pkg::NUM_PORTS-1:0][7:0] latch_r;
  logic [port_latch_pkg::NUM_PORTS-1:0][7:0] latch_nxt;
  logic [port_latch_pkg::NUM_PORTS-1:0][7:0] oe_r;
  logic [port_latch_pkg::NUM_PORTS-1:0][7:0] oe_nxt;
  logic [port_latch_pkg::NUM_PORTS-1:0][7:0] view;
  logic [port_latch_pkg::NUM_PORTS-1:0][7:0] rd_lanes;

  logic [7:0] rd_data_nxt;
  logic [7:0] rd_data_r;
  logic rd_valid_nxt;
  logic rd_valid_r;

  // request decode
  assign wr_hit = req.wr ? port_hit(req.addr) : '0;
  assign rd_hit = req.rd ? port_hit(req.addr) : '0;
  assign rd_miss = no_hit(rd_hit);
  assign lane_sel = lane_select(req.bit_op, req.bit_sel);
  assign lane_val = lane_value(req.bit_op, req.wdata);

  // ******************************************************
  // per-port latches and buffers
  // ******************************************************
  genvar p;

  generate
    for (p = 0; p < port_latch_pkg::NUM_PORTS; p++) begin : g_port
      localparam logic [7:0] MASK = port_latch_pkg::PORT_PIN_MASKS[p];
      logic [7:0] dir_pins;
      logic [7:0] clk_hide;
      logic [7:0] raw_view;

      // direction of the pins that exist
      always_comb begin
        dir_pins = pin_direction_bit[p] & MASK;
      end

      // latch: lanes this write may touch here; holes never open
      always_comb begin
        wr_lanes[p] = 8'h00;
        if (wr_hit[p]) begin
          wr_lanes[p] = lane_sel & MASK;
        end
      end

      always_comb begin
        latch_nxt[p] = merge_lanes(latch_r[p], lane_val, wr_lanes[p]);
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          latch_r[p] <= port_latch_pkg::LATCH_RESET;
        end else begin
          latch_r[p] <= latch_nxt[p];
        end
      end

      // buffer enable follows direction one clock later, so it leaves a flop
      always_comb begin
        oe_nxt[p] = ~dir_pins & MASK;
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          oe_r[p] <= port_latch_pkg::OE_RESET;
        end else begin
          oe_r[p] <= oe_nxt[p];
        end
      end

      // read view: clock pins hide the latch from reads only, the pin still drives
      always_comb begin
        clk_hide = clock_pin_mask(p, ext_clock_mode);
      end

      always_comb begin
        raw_view = pin_view(dir_pins, pin_in[p], latch_r[p]);
      end

      always_comb begin
        view[p] = raw_view & MASK & ~clk_hide;
      end

      always_comb begin
        rd_lanes[p] = 8'h00;
        if (rd_hit[p]) begin
          rd_lanes[p] = view[p];
        end
      end
    end
  endgenerate

  // ******************************************************
  // pin outputs
  // ******************************************************
  assign pin_out = latch_r;
  assign pin_oe = oe_r;

  // ******************************************************
  // read path
  // ******************************************************
  // data holds until the next read; a read beside a write sees the old latch
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (req.rd) begin
      if (rd_miss) begin
        rd_data_nxt = port_latch_pkg::UNMAPPED_READ;
      end else begin
        rd_data_nxt = merge_reads(rd_lanes);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= port_latch_pkg::RD_DATA_RESET;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // ******************************************************
  // read strobe
  // ******************************************************
  always_comb begin
    rd_valid_nxt = req.rd;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_r <= port_latch_pkg::RD_VALID_RESET;
    end else begin
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

endmodule

// File: pkg/port_latch_pkg.sv
package port_latch_pkg;

  // ******************************************************
  // port map
  // ******************************************************
  localparam int NUM_PORTS = 10;
  localparam logic [15:0] PORT0_DATA_LATCH_OFFSET = 16'hff00;
  localparam logic [15:0] PORT1_DATA_LATCH_OFFSET = 16'hff01;
  localparam logic [15:0] PORT2_DATA_LATCH_OFFSET = 16'hff02;
  localparam logic [15:0] PORT3_DATA_LATCH_OFFSET = 16'hff03;
  localparam logic [15:0] PORT4_DATA_LATCH_OFFSET = 16'hff04;
  localparam logic [15:0] PORT6_DATA_LATCH_OFFSET = 16'hff06;
  localparam logic [15:0] PORT7_DATA_LATCH_OFFSET = 16'hff07;
  localparam logic [15:0] PORT12_DATA_LATCH_OFFSET = 16'hff0c;
  localparam logic [15:0] PORT13_DATA_LATCH_OFFSET = 16'hff0d;
  localparam logic [15:0] PORT14_DATA_LATCH_OFFSET = 16'hff0e;

  localparam logic [NUM_PORTS-1:0][15:0] PORT_OFFSETS = {
    PORT14_DATA_LATCH_OFFSET, PORT13_DATA_LATCH_OFFSET, PORT12_DATA_LATCH_OFFSET,
    PORT7_DATA_LATCH_OFFSET, PORT6_DATA_LATCH_OFFSET, PORT4_DATA_LATCH_OFFSET,
    PORT3_DATA_LATCH_OFFSET, PORT2_DATA_LATCH_OFFSET, PORT1_DATA_LATCH_OFFSET,
    PORT0_DATA_LATCH_OFFSET};

  // implemented pins per port, index order as above
  localparam logic [NUM_PORTS-1:0][7:0] PORT_PIN_MASKS = {
    8'h01, 8'h01, 8'h1f, 8'h3f, 8'h0f, 8'h03, 8'h0f, 8'hff, 8'hff, 8'h03};

  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] OE_RESET = 8'h00;
  localparam logic [7:0] RD_DATA_RESET = 8'h00;
  localparam logic RD_VALID_RESET = 1'b0;
  localparam int PORT12_INDEX = 7;
  localparam int CLOCK_PIN_A_BIT = 1;
  localparam int CLOCK_PIN_B_BIT = 2;

  // ******************************************************
  // access request
  // ******************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [2:0] bit_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// File: testbench/port_latch_asserts.sv
`timescale 1ns/1ps
module port_latch_asserts (input logic clk, reset_n, input port_latch_pkg::reg_req_t req,
  input logic [9:0][7:0] pin_direction_bit, pin_in, pin_out, pin_oe,
  input logic [1:0] ext_clock_mode, input logic [7:0] rd_data, input logic rd_valid);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_oe_dir: assert property ($past(reset_n) |->
    pin_oe[1] == ~$past(pin_direction_bit[1])) else $error("oe");
  a_byte_wr: assert property (req.wr && !req.bit_op && req.addr == 16'hff01
    |=> pin_out[1] == $past(req.wdata)) else $error("byte wr");
  a_bit_wr: assert property (req.wr && req.bit_op && req.addr == 16'hff02
    |=> pin_out[2][$past(req.bit_sel)] == $past(req.wdata[0])) else $error("bit wr");
  a_rd_view: assert property (req.rd && !req.wr && req.addr == 16'hff01 |=> rd_valid &&
    rd_data == $past(pin_direction_bit[1] & pin_in[1] | ~pin_direction_bit[1] & pin_out[1]))
    else $error("rd view");
  a_rst_clr: assert property ($rose(reset_n) |-> pin_out == '0) else $error("rst");
  a_clk_pin: assert property (req.rd && req.addr == 16'hff0c && ext_clock_mode[0]
    |=> !rd_data[1]) else $error("clk pin");
  a_clk_pin_b: assert property (req.rd && req.addr == 16'hff0c && ext_clock_mode[1]
    |=> !rd_data[2]) else $error("clk pin b");
  a_oe_holes: assert property (pin_oe[0][7:2] == 6'h00) else $error("oe holes");
  a_no_pin: assert property (req.rd && req.addr == 16'hff08
    |=> !rd_data) else $error("no pin");
  c_bit: cover property (req.wr && req.bit_op);
  c_mix: cover property (rd_valid && rd_data == 8'hf5);
  c_clk: cover property (req.rd && ext_clock_mode[0]);
  c_rst: cover property ($rose(reset_n));
endmodule
bind port_data_latch_and_direction port_latch_asserts chk_i (.*);

// File: testbench/board_pins.sv
`timescale 1ns/1ps
module board_pins (input logic [9:0][7:0] pin_out, pin_oe, drv, output logic [9:0][7:0] pin_in);
  assign pin_in = pin_oe & pin_out | ~pin_oe & drv;
endmodule

// File: testbench/port_data_latch_and_direction_tb.sv
`timescale 1ns/1ps
module port_data_latch_and_direction_tb;
  port_latch_pkg::reg_req_t req = '0;
  logic clk = 0, reset_n = 0, rv;
  logic [1:0] ecm = '0;
  logic [7:0] rdd;
  logic [9:0][7:0] pi, po, oe, drv = '0;
  logic [9:0][7:0] dir = {8'hc0, 8'h00, 8'he0, 24'h0, 8'hf0, 16'h0, 8'h80};
  int num_errors = 0, num_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  port_data_latch_and_direction uut (.clk, .reset_n, .req, .pin_direction_bit(dir),
    .ext_clock_mode(ecm), .pin_in(pi), .pin_out(po), .pin_oe(oe), .rd_data(rdd), .rd_valid(rv));
  board_pins brd (.pin_out(po), .pin_oe(oe), .drv, .pin_in(pi));
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) close_out;
  end
  task acc(input logic w, r, b, input logic [2:0] s, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk) req = '{w, r, b, s, a, d};
    @(negedge clk) req = '0;
  endtask
  task chk(input string n, input logic [7:0] e, g);
    num_checks++;
    num_errors += int'(g !== e);
    if (g !== e) $display("MISMATCH %s exp %h got %h", n, e, g);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    acc(0, 1, 0, 0, a, 8'h00);
    chk("rd_data", e, rv ? rdd : 8'hxx);
  endtask
  task t_out;
    acc(1, 0, 0, 0, 16'hff01, 8'ha5);
    {dir[1], drv[1]} = 16'hf0ff;
    rd(16'hff01, 8'hf5);
    acc(1, 0, 0, 0, 16'hff0c, 8'hff);
    ecm = 2'b01;
    rd(16'hff0c, 8'h1d);
    ecm = 2'b10;
    rd(16'hff0c, 8'h1b);
    chk("pin_oe1", 8'h0f, oe[1]);
    chk("pin_oe0", 8'h03, oe[0]);
    chk("pin_out1", 8'ha5, po[1]);
  endtask
  task t_rst;
    @(negedge clk) reset_n = 0;
    @(negedge clk) reset_n = 1;
    chk("pin_out1", 8'h00, po[1]);
    rd(16'hff02, 8'h00);
  endtask
  task t_bits;
    acc(1, 0, 1, 3'd3, 16'hff02, 8'h01);
    acc(1, 0, 1, 3'd5, 16'hff02, 8'hff);
    rd(16'hff02, 8'h28);
    acc(1, 0, 0, 0, 16'hff00, 8'hff);
    rd(16'hff00, 8'h03);
    rd(16'hff08, 8'h00);
  endtask
  task close_out;
    num_errors += int'(cyc >= 2000);
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100 reset_n = 1;
    t_bits;
    t_out;
    t_rst;
    close_out;
  end
endmodule
